/* File: tcdc_channel.sv */
// Timer channel: event counter, frequency divider and pulse interval capture.
//
// Function
// - event start loads compare, sets enabled
// - event edge decrements; zero reloads, interrupts
// - start and stop bits self-clear
// - stop clears enabled, holds counter
// - compare change applies at next reload
// - divider loads compare at first edge
// - start behaviour gates first interrupt, toggle
// - divider zero toggles output and reloads
// - output frequency follows compare and edges
// - divider only on first channel
// - output enable gates counting toggles
// - stop holds output, software sets it
// - unit disable initializes, blocks writes
// - per-channel input noise filter
// - capture counts up from zero
// - capture edge copies, clears, interrupts
// - capture updates overflow from wrap
// - many wraps flag as one
// - start while enabled captures in software
// - interval from overflow and capture
// - input sampled on operation clock
// - capture start interrupts if behaviour set
`default_nettype none
module tcdc_channel
    import tcdc_pkg::*;
#(
    parameter bit          HAS_DIVIDER = 1'b1,      // set only on the first channel of the first unit
    parameter int unsigned FILTER_LEN  = FILT_LEN   // samples a filtered level must hold
) (
    input  wire logic              core_clk,           // operation clock, 200 MHz
    input  wire logic              rst_b,              // async reset, active low
    input  wire logic [ADDR_W-1:0] reg_addr,           // register byte address
    input  wire logic [DATA_W-1:0] reg_wdata,          // write data
    input  wire logic              reg_wr,             // write strobe
    input  wire logic              reg_rd,             // read strobe
    output logic      [DATA_W-1:0] reg_rdata,          // read data, cycle after strobe
    input  wire logic              channel_input_pin,  // external event or clock
    output logic                   channel_output_pin, // output register level
    output logic                   channel_output_oe,  // high while timer owns the pin
    output logic                   channel_interrupt   // one-cycle interrupt pulse
);
    logic              unit_enable;
    tcdc_mode_t        mode_cfg;
    logic [CNT_W-1:0]  compare_capture_value;
    logic [CNT_W-1:0]  channel_counter;
    tcdc_state_t       state;
    logic              wrap_seen;
    logic              overflow_flag;
    logic              output_enable_bit;
    logic              filt_level;
    logic              valid_edge;
    logic              channel_enabled_status;
    logic              wr_ok;
    logic              start_cmd;
    logic              stop_cmd;
    logic              out_wr;
    logic [CNT_W-1:0]  next_counter;
    tcdc_state_t       next_state;
    logic              next_irq;
    logic              next_wrap;
    logic              toggle;
    logic              capture;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign wr_ok     = reg_wr & unit_enable;
    assign start_cmd = wr_ok & hit(reg_addr, OFS_TRIGGER) & reg_wdata[START_BIT];
    assign stop_cmd  = wr_ok & hit(reg_addr, OFS_TRIGGER) & reg_wdata[STOP_BIT];
    assign out_wr    = wr_ok & hit(reg_addr, OFS_OUTPUT);
    assign channel_enabled_status = (state != ST_IDLE);

    tcdc_noise_filter #(
        .LEN(FILTER_LEN)
    ) u_filter (
        .core_clk(core_clk),
        .rst_b   (rst_b),
        .clear   (!unit_enable),
        .enable  (mode_cfg.noise_filter_en),
        .pin_in  (channel_input_pin),
        .pin_out (filt_level)
    );

    tcdc_edge_detect u_edge (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .clear     (!unit_enable),
        .edge_sel  (mode_cfg.edge_sel),
        .level     (filt_level),
        .valid_edge(valid_edge)
    );

    // The unit enable itself stays writable, otherwise the unit could never be woken.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            unit_enable <= 1'b0;
        end else if (reg_wr && hit(reg_addr, OFS_UNIT)) begin
            unit_enable <= reg_wdata[0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_cfg          <= MODE_RST;
            output_enable_bit <= 1'b0;
        end else if (!unit_enable) begin
            mode_cfg          <= MODE_RST;
            output_enable_bit <= 1'b0;
        end else begin
            if (wr_ok && hit(reg_addr, OFS_MODE)) begin
                mode_cfg <= tcdc_mode_t'(reg_wdata[$bits(tcdc_mode_t)-1:0]);
            end
            if (out_wr) begin
                output_enable_bit <= reg_wdata[OE_BIT];
            end
        end
    end

    // Channel engine; stop has priority over start within one write.
    always_comb begin
        next_counter = channel_counter;
        next_state   = state;
        next_irq     = 1'b0;
        next_wrap    = wrap_seen;
        toggle       = 1'b0;
        capture      = 1'b0;
        if (stop_cmd) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_cmd) begin
                        case (mode_cfg.mode)
                            MODE_EVENT: begin
                                next_counter = compare_capture_value;
                                next_state   = ST_RUN;
                            end
                            MODE_DIVIDER: begin
                                if (HAS_DIVIDER) begin
                                    next_state = ST_ARM;
                                end
                            end
                            MODE_CAPTURE: begin
                                next_counter = COUNTER_RST;
                                next_wrap    = 1'b0;
                                next_irq     = mode_cfg.start_behaviour;
                                next_state   = ST_RUN;
                            end
                            default: begin
                                next_state = ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_ARM: begin
                    if (valid_edge) begin
                        next_counter = compare_capture_value;
                        next_irq     = mode_cfg.start_behaviour;
                        toggle       = mode_cfg.start_behaviour;
                        next_state   = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (mode_cfg.mode == MODE_CAPTURE) begin
                        capture = valid_edge | start_cmd;
                        if (capture) begin
                            next_counter = COUNTER_RST;
                            next_irq     = 1'b1;
                            next_wrap    = 1'b0;
                        end else begin
                            next_counter = channel_counter + 16'h0001;
                            if (channel_counter == COUNTER_TOP) begin
                                next_wrap = 1'b1;
                            end
                        end
                    end else if (valid_edge) begin
                        // period is compare plus one edges
                        if (channel_counter == COUNTER_RST) begin
                            next_counter = compare_capture_value;
                            next_irq     = 1'b1;
                            toggle       = 1'b1;
                        end else begin
                            next_counter = channel_counter - 16'h0001;
                        end
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            channel_counter   <= COUNTER_RST;
            state             <= ST_IDLE;
            wrap_seen         <= 1'b0;
            channel_interrupt <= 1'b0;
        end else if (!unit_enable) begin
            channel_counter   <= COUNTER_RST;
            state             <= ST_IDLE;
            wrap_seen         <= 1'b0;
            channel_interrupt <= 1'b0;
        end else begin
            channel_counter   <= next_counter;
            state             <= next_state;
            wrap_seen         <= next_wrap;
            channel_interrupt <= next_irq;
        end
    end

    // Capture from the engine wins over a software write in the same cycle.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_capture_value <= COMPARE_RST;
        end else if (!unit_enable) begin
            compare_capture_value <= COMPARE_RST;
        end else if (capture && !stop_cmd) begin
            compare_capture_value <= channel_counter;
        end else if (wr_ok && hit(reg_addr, OFS_COMPARE)) begin
            compare_capture_value <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            overflow_flag <= 1'b0;
        end else if (!unit_enable) begin
            overflow_flag <= 1'b0;
        end else if (capture && !stop_cmd) begin
            overflow_flag <= wrap_seen;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            channel_output_pin <= 1'b0;
        end else if (!unit_enable) begin
            channel_output_pin <= 1'b0;
        end else if (out_wr) begin
            channel_output_pin <= reg_wdata[OUT_BIT];
        end else if (toggle && output_enable_bit && !stop_cmd) begin
            channel_output_pin <= ~channel_output_pin;
        end
    end

    assign channel_output_oe = unit_enable;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_UNIT:    reg_rdata <= {15'h0000, unit_enable};
                OFS_MODE:    reg_rdata <= {{(DATA_W-$bits(tcdc_mode_t)){1'b0}}, mode_cfg};
                OFS_COMPARE: reg_rdata <= compare_capture_value;
                OFS_COUNTER: reg_rdata <= channel_counter;
                OFS_STATUS:  reg_rdata <= {14'h0000, channel_enabled_status, overflow_flag};
                OFS_OUTPUT:  reg_rdata <= {14'h0000, output_enable_bit, channel_output_pin};
                default:     reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_run(logic [1:0] m);
        unit_enable && !stop_cmd && state == ST_RUN && mode_cfg.mode == m;
    endsequence

    sequence s_cap_evt;
        s_run(MODE_CAPTURE) ##0 (valid_edge || start_cmd);
    endsequence

    a_event_start_load: assert property (
        unit_enable && start_cmd && !stop_cmd && state == ST_IDLE && mode_cfg.mode == MODE_EVENT
        |=> channel_enabled_status && channel_counter == $past(compare_capture_value))
        else $error("event start did not load compare");

    a_event_zero_reload: assert property (
        s_run(MODE_EVENT) ##0 (valid_edge && channel_counter == COUNTER_RST)
        |=> channel_counter == $past(compare_capture_value) && channel_interrupt)
        else $error("event zero did not reload and interrupt");

    a_event_step_down: assert property (
        s_run(MODE_EVENT) ##0 (valid_edge && channel_counter != COUNTER_RST)
        |=> channel_counter == $past(channel_counter) - 16'h0001 && !channel_interrupt)
        else $error("event edge did not decrement");

    a_stop_holds_count: assert property (
        unit_enable && stop_cmd |=> !channel_enabled_status && $stable(channel_counter) && !channel_interrupt)
        else $error("stop did not halt channel");

    a_divider_arm_wait: assert property (
        unit_enable && !stop_cmd && state == ST_ARM && !valid_edge
        |=> state == ST_ARM && $stable(channel_counter) && !channel_interrupt)
        else $error("divider loaded before first edge");

    a_divider_zero_toggle: assert property (
        s_run(MODE_DIVIDER) ##0 (valid_edge && channel_counter == COUNTER_RST && output_enable_bit && !out_wr)
        |=> channel_output_pin != $past(channel_output_pin))
        else $error("divider zero did not toggle output");

    a_output_gate_off: assert property (
        unit_enable && !output_enable_bit && !out_wr |=> $stable(channel_output_pin))
        else $error("output moved while gated off");

    a_capture_copy_clear: assert property (
        s_cap_evt |=> compare_capture_value == $past(channel_counter)
            && channel_counter == COUNTER_RST && channel_interrupt)
        else $error("capture did not copy clear and interrupt");

    a_capture_overflow: assert property (
        s_cap_evt |=> overflow_flag == $past(wrap_seen) ##1 (!wrap_seen || $past(channel_counter) == COUNTER_TOP))
        else $error("overflow flag not taken from wrap");

    a_wrap_recorded: assert property (
        s_run(MODE_CAPTURE) ##0 (!valid_edge && !start_cmd && channel_counter == COUNTER_TOP)
        |=> wrap_seen && channel_counter == COUNTER_RST)
        else $error("counter wrap not recorded");

    a_disable_init: assert property (
        !unit_enable |=> channel_counter == COUNTER_RST && !channel_output_pin && !channel_enabled_status)
        else $error("disabled unit not initialized");

    a_trigger_reads_zero: assert property (
        reg_rd && reg_addr == OFS_TRIGGER |=> reg_rdata == 16'h0000)
        else $error("trigger register did not read zero");
endmodule : tcdc_channel
`default_nettype wire

/* File: tcdc_edge_detect.sv */
// Valid edge detector for the filtered channel input.
`default_nettype none
module tcdc_edge_detect
    import tcdc_pkg::*;
(
    input  wire logic       core_clk,  // operation clock
    input  wire logic       rst_b,     // async reset, active low
    input  wire logic       clear,     // unit disabled
    input  wire logic [1:0] edge_sel,  // falling, rising or both
    input  wire logic       level,     // filtered input level
    output logic            valid_edge // one-cycle pulse per valid edge
);
    logic prev;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 1'b0;
        end else if (clear) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    always_comb begin
        case (edge_sel)
            EDGE_FALL: valid_edge = prev & ~level;
            EDGE_RISE: valid_edge = ~prev & level;
            EDGE_BOTH: valid_edge = prev ^ level;
            default:   valid_edge = 1'b0;
        endcase
    end
endmodule : tcdc_edge_detect
`default_nettype wire

/* File: tcdc_noise_filter.sv */
// Optional noise filter on the channel input pin.
`default_nettype none
module tcdc_noise_filter
    import tcdc_pkg::*;
#(
    parameter int unsigned LEN = FILT_LEN
) (
    input  wire logic core_clk,  // operation clock
    input  wire logic rst_b,     // async reset, active low
    input  wire logic clear,     // unit disabled, hold initial state
    input  wire logic enable,    // filter engaged when high
    input  wire logic pin_in,    // raw input pin level
    output var  logic pin_out    // filtered level
);
    logic [3:0] stable_cnt;

    // While enabled, a level only passes once it has been seen on LEN consecutive samples; disabled, it passes at once.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stable_cnt <= 4'h0;
            pin_out    <= 1'b0;
        end else if (clear) begin
            stable_cnt <= 4'h0;
            pin_out    <= 1'b0;
        end else if (!enable || pin_in == pin_out) begin
            stable_cnt <= 4'h0;
            pin_out    <= pin_in;
        end else if (stable_cnt >= 4'(LEN - 1)) begin
            stable_cnt <= 4'h0;
            pin_out    <= pin_in;
        end else begin
            stable_cnt <= stable_cnt + 4'h1;
        end
    end
endmodule : tcdc_noise_filter
`default_nettype wire

/* File: tcdc_pkg.sv */
// Shared constants, register map and carrier types of the timer channel.
`default_nettype none
package tcdc_pkg;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned FILT_LEN   = 3;

    // Register byte offsets, one aligned word each.
    localparam logic [7:0] OFS_UNIT    = 8'h00;
    localparam logic [7:0] OFS_MODE    = 8'h04;
    localparam logic [7:0] OFS_COMPARE = 8'h08;
    localparam logic [7:0] OFS_COUNTER = 8'h0c;
    localparam logic [7:0] OFS_TRIGGER = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_OUTPUT  = 8'h18;

    // Bit positions inside the trigger, status and output registers.
    localparam int unsigned START_BIT  = 0;
    localparam int unsigned STOP_BIT   = 1;
    localparam int unsigned OVF_BIT    = 0;
    localparam int unsigned EN_BIT     = 1;
    localparam int unsigned OUT_BIT    = 0;
    localparam int unsigned OE_BIT     = 1;

    // Operation mode codes.
    localparam logic [1:0] MODE_EVENT   = 2'h0;
    localparam logic [1:0] MODE_DIVIDER = 2'h1;
    localparam logic [1:0] MODE_CAPTURE = 2'h2;

    // Input edge select codes.
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // Reset values and counter top value.
    localparam logic [CNT_W-1:0] COUNTER_RST = 16'h0000;
    localparam logic [CNT_W-1:0] COMPARE_RST = 16'h0000;
    localparam logic [CNT_W-1:0] COUNTER_TOP = 16'hffff;

    // Mode register layout, low bit first: mode, start behaviour, edge, start select, filter.
    typedef struct packed {
        logic       noise_filter_en;
        logic [2:0] start_trigger_select;
        logic [1:0] edge_sel;
        logic       start_behaviour;
        logic [1:0] mode;
    } tcdc_mode_t;

    localparam tcdc_mode_t MODE_RST = '0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARM  = 3'b010,
        ST_RUN  = 3'b100
    } tcdc_state_t;
endpackage : tcdc_pkg
`default_nettype wire

/* File: tcdc_pulse_src.sv */
// Behavioural pulse source standing at the channel input pin.
`default_nettype none
module tcdc_pulse_src (
    input  wire logic       core_clk, // bench clock
    input  wire logic       go,       // one-cycle burst request
    input  wire logic [7:0] count,    // pulses in the burst
    input  wire logic [7:0] half,     // cycles high, then cycles low
    output var  logic       pin,      // channel input pin level
    output var  logic       busy      // high while a burst runs
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pin = 1'b0;
        busy = 1'b0;
    end
    // The pin moves only just after an edge, so no sample lands on a change.
    always begin
        @(posedge core_clk);
        if (go) begin
            busy <= 1'b1;
            repeat (count) begin
                pin <= 1'b1;
                repeat (half) @(posedge core_clk);
                pin <= 1'b0;
                repeat (half) @(posedge core_clk);
            end
            busy <= 1'b0;
        end
    end
endmodule : tcdc_pulse_src
`default_nettype wire

/* File: test_timer_channel_event_divider_capture.sv */
// Self-checking bench for the timer channel in event, divider and capture modes.
`default_nettype none
module test_timer_channel_event_divider_capture;
    import tcdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic              core_clk, rst_b, reg_wr, reg_rd, pin, pin_out, pin_oe, irq, go, src_busy;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [7:0]        p_cnt, p_half;
    logic [15:0]       irq_n, base;
    int                err_total, samples_checked;

    tcdc_channel #(.HAS_DIVIDER(1'b1), .FILTER_LEN(3)) dut_u (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_input_pin(pin),
        .channel_output_pin(pin_out), .channel_output_oe(pin_oe), .channel_interrupt(irq));
    tcdc_pulse_src src_u (.core_clk(core_clk), .go(go), .count(p_cnt), .half(p_half),
        .pin(pin), .busy(src_busy));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (irq === 1'b1) irq_n <= irq_n + 16'h0001;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s is %h, expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Strobes drop at the edge and rise again 1 ns later, never twice in one step.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, "read data");
    endtask : rd

    task automatic pulse(input logic [7:0] n, input logic [7:0] h);
        int k;
        k = 0;
        go <= 1'b1;
        p_cnt <= n;
        p_half <= h;
        @(posedge core_clk);
        go <= 1'b0;
        #1;
        while (src_busy === 1'b1 && k < 600) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        repeat (4) @(posedge core_clk);
        #1;
    endtask : pulse

    task automatic set_mode(input logic [1:0] md, input logic sb, input logic f);
        wr(OFS_MODE, {7'h00, f, 3'h1, EDGE_RISE, sb, md});
    endtask : set_mode

    task automatic t_event();
        set_mode(MODE_EVENT, 1'b0, 1'b0);
        wr(OFS_OUTPUT, 16'h0000);
        wr(OFS_COMPARE, 16'h0002);
        wr(OFS_TRIGGER, 16'h0001);
        rd(OFS_COUNTER, 16'h0002);
        rd(OFS_STATUS, 16'h0002);
        rd(OFS_TRIGGER, 16'h0000);
        wr(OFS_COMPARE, 16'h0004);
        rd(OFS_COUNTER, 16'h0002);
        pulse(8'h03, 8'h02);
        rd(OFS_COUNTER, 16'h0004);
        chk(irq_n, 16'h0001, "interrupt count");
        chk({15'h0000, pin_out}, 16'h0000, "output pin");
        wr(OFS_TRIGGER, 16'h0002);
        rd(OFS_STATUS, 16'h0000);
        pulse(8'h01, 8'h02);
        rd(OFS_COUNTER, 16'h0004);
        set_mode(MODE_EVENT, 1'b0, 1'b1);
        wr(OFS_TRIGGER, 16'h0001);
        pulse(8'h01, 8'h01);
        rd(OFS_COUNTER, 16'h0004);
        pulse(8'h01, 8'h06);
        rd(OFS_COUNTER, 16'h0003);
        wr(OFS_TRIGGER, 16'h0002);
        $display("test event done");
    endtask : t_event

    task automatic t_divider();
        wr(OFS_OUTPUT, 16'h0002);
        set_mode(MODE_DIVIDER, 1'b1, 1'b0);
        wr(OFS_COMPARE, 16'h0001);
        wr(OFS_TRIGGER, 16'h0001);
        rd(OFS_COUNTER, 16'h0003);
        pulse(8'h01, 8'h02);
        rd(OFS_COUNTER, 16'h0001);
        chk(irq_n, 16'h0002, "interrupt count");
        chk({15'h0000, pin_out}, 16'h0001, "output pin");
        pulse(8'h02, 8'h02);
        rd(OFS_COUNTER, 16'h0001);
        chk({15'h0000, pin_out}, 16'h0000, "output pin");
        pulse(8'h02, 8'h02);
        chk({15'h0000, pin_out}, 16'h0001, "output pin");
        wr(OFS_TRIGGER, 16'h0002);
        pulse(8'h02, 8'h02);
        chk({15'h0000, pin_out}, 16'h0001, "output pin");
        wr(OFS_OUTPUT, 16'h0000);
        @(posedge core_clk);
        #1;
        chk({15'h0000, pin_out}, 16'h0000, "output pin");
        wr(OFS_OUTPUT, 16'h0002);
        wr(OFS_MODE, {7'h00, 1'b0, 3'h1, EDGE_BOTH, 1'b0, MODE_DIVIDER});
        base = irq_n;
        wr(OFS_TRIGGER, 16'h0001);
        pulse(8'h01, 8'h02);
        rd(OFS_COUNTER, 16'h0000);
        chk(irq_n, base, "interrupt count");
        chk({15'h0000, pin_out}, 16'h0000, "output pin");
        pulse(8'h01, 8'h02);
        chk({15'h0000, pin_out}, 16'h0001, "output pin");
        wr(OFS_TRIGGER, 16'h0002);
        $display("test divider done");
    endtask : t_divider

    task automatic t_capture();
        wr(OFS_MODE, {7'h00, 1'b0, 3'h1, EDGE_FALL, 1'b1, MODE_CAPTURE});
        base = irq_n;
        wr(OFS_TRIGGER, 16'h0001);
        repeat (9) @(posedge core_clk);
        wr(OFS_TRIGGER, 16'h0001);
        rd(OFS_COMPARE, 16'h0009);
        rd(OFS_STATUS, 16'h0002);
        chk(irq_n, base + 16'h0002, "interrupt count");
        wr(OFS_TRIGGER, 16'h0001);
        repeat (70000) @(posedge core_clk);
        wr(OFS_TRIGGER, 16'h0001);
        rd(OFS_COMPARE, 16'h1170);
        rd(OFS_STATUS, 16'h0003);
        wr(OFS_TRIGGER, 16'h0001);
        repeat (2) @(posedge core_clk);
        wr(OFS_TRIGGER, 16'h0001);
        rd(OFS_COMPARE, 16'h0002);
        rd(OFS_STATUS, 16'h0002);
        base = irq_n;
        pulse(8'h01, 8'h02);
        chk(irq_n, base + 16'h0001, "interrupt count");
        wr(OFS_TRIGGER, 16'h0002);
        $display("test capture done");
    endtask : t_capture

    task automatic t_unit();
        wr(OFS_OUTPUT, 16'h0001);
        wr(OFS_UNIT, 16'h0000);
        @(posedge core_clk);
        #1;
        chk({14'h0000, pin_oe, pin_out}, 16'h0000, "pin and enable");
        wr(OFS_COMPARE, 16'h0005);
        wr(OFS_UNIT, 16'h0001);
        rd(OFS_COMPARE, 16'h0000);
        rd(OFS_MODE, 16'h0000);
        rd(8'h1c, 16'h0000);
        $display("test unit done");
    endtask : t_unit

    task automatic close_out();
        $display("checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        go = 1'b0;
        p_cnt = '0;
        p_half = '0;
        irq_n = '0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1;
        wr(OFS_UNIT, 16'h0001);
        chk({15'h0000, pin_oe}, 16'h0001, "pin enable");
        t_event();
        t_divider();
        t_capture();
        t_unit();
        close_out();
    end

    // The run needs about 70200 cycles; this cuts a hang at 90000.
    initial begin
        #450000;
        err_total++;
        close_out();
    end
endmodule : test_timer_channel_event_divider_capture
`default_nettype wire
